// ---- include/monitor_regs.svh ----
/*
 * Frame layout, event indexes and timing counts of the monitor link.
 * Assumes inclusion by bare name from the include folder.
 */
`ifndef MONITOR_REGS_SVH
`define MONITOR_REGS_SVH
// ****************************************
// Frame layout, sent first bit at the MSB
// ****************************************
`define FRAME_LAST 5'h1f
`define FRAME_IDLE 32'hffffffff
`define CH0_LSB 22
`define CH1_LSB 12
`define FIELD_IDLE 10'h3ff
// ****************************************
// Event and control crossing indexes
// ****************************************
`define EV_BYTE 0
`define EV_ACK 1
`define EV_ABORT 2
`define EV_END 3
`define EV_BUSY 4
`define CS_WR 0
`define CS_RD 1
`define CS_TXC 2
`define CS_RXC 3
`define CS_SW 4
`define CS_SEL 5
// ****************************************
// Link clock divider, half period in clk cycles
// ****************************************
`define LINK_HALF_DIV 4
// Link side reset stretch in clk cycles; covers a link clock that starts late
`define LINK_RST_HOLD 6'h3f
`endif

// ---- include/monitor_pkg.sv ----
/*
 * Types shared by both ends of the monitor link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package monitor_pkg;
	// One channel slot: byte, valid bit and ack bit, both active low
	typedef struct packed {
		logic [7:0] data;
		logic       valid_n;
		logic       ack_n;
	} mon_field_type;

	typedef enum logic [5:0] {
		TX_IDLE  = 6'b000001,
		TX_FIRST = 6'b000010,
		TX_HELD  = 6'b000100,
		TX_GAP   = 6'b001000,
		TX_SEND  = 6'b010000,
		TX_END   = 6'b100000
	} tx_state_type;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_ACKED = 3'b010,
		RX_GAP   = 3'b100
	} rx_state_type;
endpackage

// ---- include/monitor_link_if.sv ----
/*
 * Serial frame link between the peer end and the device end.
 * Assumes the peer end makes the link clock and frame sync.
 */
`timescale 1ns/100ps
interface monitor_link_if;
	logic link_clk;
	logic frame_sync;
	logic down_data;
	logic up_data;

	modport peer_end (
		output link_clk,
		output frame_sync,
		output down_data,
		input  up_data
	);

	modport device_end (
		input  link_clk,
		input  frame_sync,
		input  down_data,
		output up_data
	);
endinterface

// ---- src/monitor_peer_end.sv ----
/*
 * Peer end: divides clk into the link clock, sends one frame of two
 * channel slots every 32 bits and returns the slots the device sent.
 * Assumes the user side supplies slot contents and runs the protocol.
 */
`timescale 1ns/100ps
`include "monitor_regs.svh"
module monitor_peer_end #(
	parameter int HALF_DIV = `LINK_HALF_DIV
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Link
	monitor_link_if.peer_end            link,
	// User side, sampled at each frame start
	input  wire monitor_pkg::mon_field_type down_ch0,
	input  wire monitor_pkg::mon_field_type down_ch1,
	output monitor_pkg::mon_field_type  up_ch0,
	output monitor_pkg::mon_field_type  up_ch1,
	output logic                        frame_done
);
	import monitor_pkg::*;

	typedef struct packed {
		logic [7:0]    div;
		logic [4:0]    cnt;
		logic          link_clk;
		logic          frame_sync;
		logic          down_data;
		logic [31:0]   word;
		logic          s1;
		logic          s2;
		logic [30:0]   sr;
		mon_field_type up0;
		mon_field_type up1;
		logic          done;
	} peer_state_type;

	peer_state_type st;
	peer_state_type next_st;

	// ****************************************
	// Clock divider, framing and capture
	// ****************************************
	always_comb begin
		logic [31:0] f;
		f = {st.sr, st.s2};
		next_st = st;
		next_st.done = 1'b0;
		next_st.s1 = link.up_data;
		next_st.s2 = st.s1;
		next_st.div = st.div + 8'h1;
		if (st.div == 8'(HALF_DIV - 1)) begin
			next_st.link_clk = 1'b1;
			// The pin was synchronised, so sample late in the bit
			next_st.sr = {st.sr[29:0], st.s2};
			if (st.cnt == 5'h0) begin
				next_st.up0 = f[`CH0_LSB +: 10];
				next_st.up1 = f[`CH1_LSB +: 10];
				next_st.done = 1'b1;
			end
		end
		if (st.div == 8'(2 * HALF_DIV - 1)) begin
			next_st.div = 8'h0;
			next_st.link_clk = 1'b0;
			next_st.cnt = st.cnt + 5'h1;
			next_st.frame_sync = (next_st.cnt == 5'h0);
			if (next_st.cnt == 5'h0) begin
				next_st.word = `FRAME_IDLE;
				next_st.word[`CH0_LSB +: 10] = down_ch0;
				next_st.word[`CH1_LSB +: 10] = down_ch1;
			end
			next_st.down_data = next_st.word[~next_st.cnt];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '{div: 8'h0, cnt: `FRAME_LAST, link_clk: 1'b0, frame_sync: 1'b0, down_data: 1'b1,
				word: `FRAME_IDLE, s1: 1'b1, s2: 1'b1, sr: 31'h7fffffff, up0: `FIELD_IDLE,
				up1: `FIELD_IDLE, done: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign link.link_clk = st.link_clk;
	assign link.frame_sync = st.frame_sync;
	assign link.down_data = st.down_data;
	assign up_ch0 = st.up0;
	assign up_ch1 = st.up1;
	assign frame_done = st.done;
endmodule // monitor_peer_end

// ---- src/monitor_device_end.sv ----
/*
 * Device end: processor-side monitor channel transceiver. The protocol
 * engine runs on the link clock; processor controls and status live on clk.
 * Assumes the peer end makes link_clk and frame_sync.
 */
`timescale 1ns/100ps
`include "monitor_regs.svh"
module monitor_device_end (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	// Link
	monitor_link_if.device_end              link,
	// Processor controls
	input  wire logic                       monitor_switch,
	input  wire logic                       terminal_channel_select,
	input  wire logic                       valid_bit_control,
	input  wire logic                       ack_bit_control,
	input  wire logic                       tx_irq_enable,
	input  wire logic                       rx_irq_enable,
	// Processor data strobes
	input  wire logic                       tx_wr,
	input  wire logic [7:0]                 tx_data,
	input  wire logic                       rx_rd,
	input  wire logic                       status_rd,
	// Processor status
	output logic [7:0]                      rx_byte_reg,
	output logic                            byte_received_flag,
	output logic                            ack_received_flag,
	output logic                            abort_flag,
	output logic                            end_of_reception_flag,
	output logic                            transfer_busy_flag,
	output logic                            tx_irq,
	output logic                            rx_irq,
	// Transceiver core slot, on link_clk
	input  wire monitor_pkg::mon_field_type core_up,
	output monitor_pkg::mon_field_type      core_down
);
	import monitor_pkg::*;

	// ****************************************
	// State types
	// ****************************************
	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [3:0] last;
		logic [3:0] flags;
		logic [7:0] rx_byte;
		logic [7:0] tx_byte;
		logic       wr_tgl;
		logic       rd_tgl;
		logic [5:0] rst_hold;
		logic       rst_req;
	} cpu_state_type;

	typedef struct packed {
		logic [5:0]    s1;
		logic [5:0]    s2;
		logic          wr_last;
		logic          rd_last;
		logic [4:0]    cnt;
		logic [30:0]   sr;
		logic [31:0]   word;
		logic          up_data;
		tx_state_type  txs;
		rx_state_type  rxs;
		logic [7:0]    tx_hold;
		logic          tx_new;
		logic          ack_due;
		logic          unread;
		logic          in_msg;
		logic          prev_a;
		logic          prev_v;
		logic [7:0]    rx_data;
		logic [3:0]    tgl;
		logic          busy;
		mon_field_type core_down;
	} link_state_type;

	cpu_state_type  cs;
	cpu_state_type  next_cs;
	link_state_type ls;
	link_state_type next_ls;
	logic           rst_s1;
	logic           link_rst;

	// ****************************************
	// Processor side
	// ****************************************
	always_comb begin
		logic [3:0] edges;
		// Toggles left over from before a reset must not set flags
		edges = cs.rst_req ? 4'h0 : cs.s2[3:0] ^ cs.last;
		next_cs = cs;
		next_cs.s1 = {ls.busy, ls.tgl};
		next_cs.s2 = cs.s1;
		next_cs.last = cs.s2[3:0];
		// The link clock stands still in reset, so the link reset outlasts it
		next_cs.rst_req = (cs.rst_hold != 6'h0);
		if (cs.rst_hold != 6'h0) begin
			next_cs.rst_hold = cs.rst_hold - 6'h1;
		end
		// Set beats a clear in the same cycle
		next_cs.flags = edges | (cs.flags & {4{~status_rd}});
		if (edges[`EV_BYTE]) begin
			next_cs.rx_byte = ls.rx_data;
		end
		if (tx_wr) begin
			next_cs.tx_byte = tx_data;
			next_cs.wr_tgl = ~cs.wr_tgl;
		end
		if (rx_rd) begin
			next_cs.rd_tgl = ~cs.rd_tgl;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cs <= '{s1: 5'h0, s2: 5'h0, last: 4'h0, flags: 4'h0, rx_byte: 8'h0, tx_byte: 8'h0, wr_tgl: 1'b0,
				rd_tgl: 1'b0, rst_hold: `LINK_RST_HOLD, rst_req: 1'b1};
		end else begin
			cs <= next_cs;
		end
	end

	assign rx_byte_reg = cs.rx_byte;
	assign byte_received_flag = cs.flags[`EV_BYTE];
	assign ack_received_flag = cs.flags[`EV_ACK];
	assign abort_flag = cs.flags[`EV_ABORT];
	assign end_of_reception_flag = cs.flags[`EV_END];
	assign transfer_busy_flag = cs.s2[`EV_BUSY];
	assign tx_irq = tx_irq_enable & (cs.flags[`EV_ACK] | cs.flags[`EV_ABORT]);
	assign rx_irq = cs.flags[`EV_BYTE] | (rx_irq_enable & cs.flags[`EV_END]);

	// ****************************************
	// Link side
	// ****************************************
	// Stretched reset reaches the link domain two link edges late
	always_ff @(posedge link.link_clk) begin
		rst_s1 <= cs.rst_req;
		link_rst <= rst_s1;
	end

	always_comb begin
		logic [31:0]   f;
		logic [31:0]   w;
		mon_field_type eng_in;
		mon_field_type eng_out;
		logic          sw;
		logic          use_ch1;
		logic          pass0;
		logic          tx_en;
		logic          rx_en;
		logic          pa;
		logic          pv;
		logic [3:0]    ev;
		f = {ls.sr, link.down_data};
		w = `FRAME_IDLE;
		sw = ls.s2[`CS_SW];
		use_ch1 = ls.s2[`CS_SEL];
		pass0 = ~sw | use_ch1;
		tx_en = sw & ls.s2[`CS_TXC];
		rx_en = sw & ls.s2[`CS_RXC];
		eng_in = use_ch1 ? f[`CH1_LSB +: 10] : f[`CH0_LSB +: 10];
		pa = sw & ~eng_in.ack_n;
		pv = sw & ~eng_in.valid_n;
		ev = 4'h0;
		eng_out = `FIELD_IDLE;
		next_ls = ls;
		next_ls.s1 = {terminal_channel_select, monitor_switch, ack_bit_control, valid_bit_control,
			cs.rd_tgl, cs.wr_tgl};
		next_ls.s2 = ls.s1;
		next_ls.wr_last = ls.s2[`CS_WR];
		next_ls.rd_last = ls.s2[`CS_RD];
		if (ls.s2[`CS_WR] ^ ls.wr_last) begin
			next_ls.tx_hold = cs.tx_byte;
			next_ls.tx_new = 1'b1;
		end
		// A read may come any number of frames later
		if ((ls.s2[`CS_RD] ^ ls.rd_last) && ls.unread) begin
			next_ls.ack_due = 1'b1;
			next_ls.unread = 1'b0;
		end
		next_ls.cnt = link.frame_sync ? 5'h0 : ls.cnt + 5'h1;
		next_ls.sr = {ls.sr[29:0], link.down_data};
		if (next_ls.cnt == `FRAME_LAST) begin
			next_ls.prev_a = pa;
			next_ls.prev_v = pv;
			case (ls.txs)
				TX_IDLE: if (tx_en) begin
					next_ls.txs = TX_FIRST;
					next_ls.tx_new = 1'b0;
				end
				TX_FIRST: if (!tx_en) begin
					next_ls.txs = TX_END;
				end else if (pa) begin
					next_ls.txs = TX_HELD;
					ev[`EV_ACK] = 1'b1;
				end
				TX_HELD: if (!tx_en) begin
					next_ls.txs = TX_END;
				end else if (!pa && !ls.prev_a) begin
					next_ls.txs = TX_END;
					ev[`EV_ABORT] = 1'b1;
				end else if (next_ls.tx_new) begin
					next_ls.txs = TX_GAP;
					next_ls.tx_new = 1'b0;
				end
				TX_GAP: next_ls.txs = tx_en ? TX_SEND : TX_END;
				TX_SEND: if (!tx_en) begin
					next_ls.txs = TX_END;
				end else if (!pa && !ls.prev_a) begin
					next_ls.txs = TX_END;
					ev[`EV_ABORT] = 1'b1;
				end else if (pa && !ls.prev_a) begin
					next_ls.txs = TX_HELD;
					ev[`EV_ACK] = 1'b1;
				end
				TX_END: if (!pa && !tx_en) begin
					next_ls.txs = TX_IDLE;
				end
				default: next_ls.txs = TX_IDLE;
			endcase
			// Receive side
			if (pv && !ls.prev_v) begin
				next_ls.rx_data = eng_in.data;
				next_ls.unread = 1'b1;
				next_ls.in_msg = 1'b1;
				ev[`EV_BYTE] = 1'b1;
			end else if (!pv && !ls.prev_v && ls.in_msg) begin
				next_ls.in_msg = 1'b0;
				ev[`EV_END] = 1'b1;
			end
			case (ls.rxs)
				RX_IDLE: if (rx_en && next_ls.ack_due) begin
					next_ls.rxs = RX_ACKED;
					next_ls.ack_due = 1'b0;
				end
				RX_ACKED: if (!rx_en) begin
					next_ls.rxs = RX_IDLE;
				end else if (next_ls.ack_due) begin
					next_ls.rxs = RX_GAP;
					next_ls.ack_due = 1'b0;
				end
				RX_GAP: next_ls.rxs = rx_en ? RX_ACKED : RX_IDLE;
				default: next_ls.rxs = RX_IDLE;
			endcase
			// Byte resent every frame while valid is driven
			eng_out.data = ls.tx_hold;
			eng_out.valid_n = ~(next_ls.txs == TX_FIRST || next_ls.txs == TX_HELD || next_ls.txs == TX_SEND);
			eng_out.ack_n = (next_ls.rxs != RX_ACKED);
			if (pass0) begin
				w[`CH0_LSB +: 10] = core_up;
			end
			if (sw) begin
				if (use_ch1) begin
					w[`CH1_LSB +: 10] = eng_out;
				end else begin
					w[`CH0_LSB +: 10] = eng_out;
				end
			end
			next_ls.word = w;
			next_ls.core_down = pass0 ? f[`CH0_LSB +: 10] : `FIELD_IDLE;
		end
		next_ls.tgl = ls.tgl ^ ev;
		next_ls.busy = (next_ls.txs != TX_IDLE);
		next_ls.up_data = ls.word[~next_ls.cnt];
	end

	always_ff @(posedge link.link_clk) begin
		if (link_rst) begin
			ls <= '{s1: 6'h0, s2: 6'h0, wr_last: 1'b0, rd_last: 1'b0, cnt: 5'h0, sr: 31'h7fffffff,
				word: `FRAME_IDLE, up_data: 1'b1, txs: TX_IDLE, rxs: RX_IDLE, tx_hold: 8'h0,
				tx_new: 1'b0, ack_due: 1'b0, unread: 1'b0, in_msg: 1'b0, prev_a: 1'b0,
				prev_v: 1'b0, rx_data: 8'h0, tgl: 4'h0, busy: 1'b0, core_down: `FIELD_IDLE};
		end else begin
			ls <= next_ls;
		end
	end

	assign link.up_data = ls.up_data;
	assign core_down = ls.core_down;
endmodule // monitor_device_end

// ---- testbench/monitor_link_chk.sv ----
/*
 * Link checker: link clock halves, frame sync spacing, idle tail bits.
 * Assumes clk and sys_rst of the peer end and the 32-bit frame layout.
 */
`timescale 1ns/100ps
module monitor_link_chk #(
	parameter int HALF_DIV = 4
) (
	// Clock and reset
	input wire logic	clk,
	input wire logic	sys_rst,
	// Link
	input wire logic	link_clk,
	input wire logic	frame_sync,
	input wire logic	down_data,
	input wire logic	up_data
);
	// ********
	// Frame tracker
	// ********
	typedef struct packed {
		logic		link_q;
		logic		toggled;
		logic		synced;
		logic [4:0]	pos;
		logic [7:0]	hcnt;
	} chk_state_type;
	chk_state_type	st;
	chk_state_type	next_st;
	logic		turn;
	logic		rise;
	assign turn = link_clk != st.link_q;
	assign rise = link_clk && !st.link_q;
	// Tracked from clk, so it resets even while the link clock stands low
	always_comb begin
		next_st = st;
		next_st.link_q = link_clk;
		next_st.hcnt = turn ? 8'h00 : st.hcnt + 8'h01;
		if (turn)
			next_st.toggled = 1'b1;
		if (rise) begin
			next_st.pos = frame_sync ? 5'h01 : st.pos + 5'h01;
			next_st.synced = st.synced | frame_sync;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			st <= '0;
		else
			st <= next_st;
	end
	// ********
	// Assertions
	// ********
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_link_half: assert property (turn && st.toggled |-> st.hcnt == 8'(HALF_DIV - 1))
		else $error("link clock half period off");
	a_sync_gap: assert property (rise && st.synced && st.pos != 5'h00 |-> !frame_sync)
		else $error("frame sync inside a frame");
	a_sync_wrap: assert property (rise && st.synced && st.pos == 5'h00 |-> frame_sync)
		else $error("frame sync missing after 32 bits");
	a_down_tail: assert property (rise && st.synced && st.pos >= 5'h14 |-> down_data)
		else $error("down tail bit not idle");
	// Window leaves room for a short lag of the device's up bits
	a_up_tail: assert property (rise && st.synced && st.pos >= 5'h16 && st.pos <= 5'h1d |-> up_data)
		else $error("up tail bit not idle");
	a_down_on_fall: assert property ($changed(down_data) |-> !link_clk)
		else $error("down data moved while link clock high");
	a_sync_on_fall: assert property ($changed(frame_sync) |-> !link_clk)
		else $error("frame sync moved while link clock high");
	a_up_hold: assert property ($changed(up_data) |=> $stable(up_data) [*3])
		else $error("up data bit too short");
	c_frame: cover property (rise && frame_sync);
	c_up_low: cover property (rise && st.synced && !up_data);
	c_down_low: cover property (rise && st.synced && !down_data);
endmodule // monitor_link_chk

// ---- testbench/tb.sv ----
/*
 * Bench for both link ends: routing table, transmit, abort, receive, reset.
 * Assumes package, interface, both ends and the link checker compile first.
 */
`timescale 1ns/100ps
module tb;
	import monitor_pkg::*;
	// ********
	// Stimulus and observation
	// ********
	typedef struct packed {
		logic [1:0]	sw_sel;
		logic [9:0]	core;
		logic [9:0]	up0;
		logic [9:0]	m0;
		logic [9:0]	up1;
		logic [9:0]	m1;
	} row_type;
	localparam int	HALF = 4;
	localparam row_type	ROWS [3] = '{
		'{2'h0, 10'h15a, 10'h0c3, 10'h3ff, 10'h3ff, 10'h3ff},
		'{2'h3, 10'h15a, 10'h0c3, 10'h3ff, 10'h003, 10'h003},
		'{2'h1, 10'h3ff, 10'h003, 10'h003, 10'h3ff, 10'h3ff}};
	logic		clk = 1'b0;
	logic		sys_rst = 1'b1;
	logic [5:0]	ctl = 6'h00;
	logic [2:0]	stb = 3'h0;
	logic [7:0]	tx_data = 8'h00;
	mon_field_type	down_ch0 = 10'h3ff;
	mon_field_type	up_ch0;
	mon_field_type	up_ch1;
	mon_field_type	core_down;
	logic		frame_done;
	logic [7:0]	rx_byte_reg;
	logic [4:0]	fl;
	logic [1:0]	irq;
	int		compares = 0;
	int		fail_count = 0;
	int		c;
	always #5 clk = ~clk;
	// ********
	// Both ends and the link checker
	// ********
	monitor_link_if link ();
	monitor_peer_end #(.HALF_DIV(HALF)) monitor_peer_end_i (.clk(clk), .sys_rst(sys_rst), .link(link),
		.down_ch0(down_ch0), .down_ch1(10'h3ff), .up_ch0(up_ch0), .up_ch1(up_ch1), .frame_done(frame_done));
	monitor_device_end monitor_device_end_i (.clk(clk), .sys_rst(sys_rst), .link(link),
		.monitor_switch(ctl[0]), .terminal_channel_select(ctl[1]), .valid_bit_control(ctl[2]),
		.ack_bit_control(ctl[3]), .tx_irq_enable(ctl[4]), .rx_irq_enable(ctl[5]),
		.tx_wr(stb[0]), .tx_data(tx_data), .rx_rd(stb[1]), .status_rd(stb[2]),
		.rx_byte_reg(rx_byte_reg), .byte_received_flag(fl[0]), .ack_received_flag(fl[1]),
		.abort_flag(fl[2]), .end_of_reception_flag(fl[3]), .transfer_busy_flag(fl[4]),
		.tx_irq(irq[0]), .rx_irq(irq[1]), .core_up(10'h0c3), .core_down(core_down));
	monitor_link_chk #(.HALF_DIV(HALF)) monitor_link_chk_i (.clk(clk), .sys_rst(sys_rst),
		.link_clk(link.link_clk), .frame_sync(link.frame_sync), .down_data(link.down_data), .up_data(link.up_data));
	// ********
	// Tasks
	// ********
	task automatic summarize();
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic frames(input int n);
		int k;
		repeat (n) begin
			k = 0;
			do begin
				@(negedge clk);
				k++;
			end while (frame_done !== 1'b1 && k < 600);
			if (frame_done !== 1'b1) begin
				fail_count++;
				summarize();
			end
		end
	endtask
	// Spare cycle keeps two pulses from landing in one time step
	task automatic pulse(input int k);
		stb[k] = 1'b1;
		@(negedge clk);
		stb = 3'h0;
		@(negedge clk);
	endtask
	task automatic count_high(input int b);
		c = 0;
		repeat (5) begin
			frames(1);
			if (up_ch0[b] === 1'b1)
				c++;
		end
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	// ********
	// Sequence
	// ********
	initial begin
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		frames(2);
		for (int i = 0; i < 3; i++) begin
			ctl[1:0] = ROWS[i].sw_sel;
			down_ch0 = 10'h15a;
			frames(4);
			chk(core_down, ROWS[i].core);
			chk(up_ch0 & ROWS[i].m0, ROWS[i].up0);
			chk(up_ch1 & ROWS[i].m1, ROWS[i].up1);
		end
		done("routing");
		down_ch0 = 10'h3ff;
		ctl = 6'h11;
		frames(2);
		tx_data = 8'h5c;
		pulse(0);
		ctl = 6'h15;
		frames(3);
		chk(up_ch0, 10'h171);
		frames(1);
		chk(up_ch0, 10'h171);
		chk(fl[4], 1'b1);
		chk(irq[0], 1'b0);
		down_ch0 = 10'h3fe;
		frames(3);
		chk(fl[1], 1'b1);
		chk(irq[0], 1'b1);
		chk(up_ch0[1], 1'b0);
		pulse(2);
		tx_data = 8'ha3;
		pulse(0);
		count_high(1);
		chk(10'(c), 10'h001);
		chk(up_ch0, 10'h28d);
		down_ch0 = 10'h3ff;
		frames(1);
		down_ch0 = 10'h3fe;
		frames(3);
		chk(fl[1], 1'b1);
		chk(fl[2], 1'b0);
		ctl = 6'h11;
		frames(3);
		chk(up_ch0[1], 1'b1);
		chk(fl[4], 1'b1);
		down_ch0 = 10'h3ff;
		frames(3);
		chk(fl[4], 1'b0);
		done("transmit");
		pulse(2);
		chk(fl[4], 1'b0);
		tx_data = 8'h11;
		pulse(0);
		ctl = 6'h15;
		frames(3);
		down_ch0 = 10'h3fe;
		frames(3);
		pulse(2);
		down_ch0 = 10'h3ff;
		frames(4);
		chk(fl[2], 1'b1);
		chk(irq[0], 1'b1);
		ctl = 6'h05;
		@(negedge clk);
		chk(irq[0], 1'b0);
		ctl = 6'h01;
		frames(3);
		chk(fl[4], 1'b0);
		done("abort");
		pulse(2);
		down_ch0 = 10'h1f9;
		frames(3);
		chk(fl[0], 1'b1);
		chk(rx_byte_reg, 8'h7e);
		chk(irq[1], 1'b1);
		chk(up_ch0[0], 1'b1);
		ctl = 6'h29;
		pulse(1);
		frames(3);
		chk(up_ch0[0], 1'b0);
		pulse(2);
		down_ch0 = 10'h207;
		frames(1);
		down_ch0 = 10'h205;
		frames(3);
		chk(fl[0], 1'b1);
		chk(rx_byte_reg, 8'h81);
		chk(fl[3], 1'b0);
		frames(6);
		chk(up_ch0[0], 1'b0);
		pulse(1);
		count_high(0);
		chk(10'(c), 10'h001);
		pulse(2);
		down_ch0 = 10'h207;
		frames(4);
		chk(fl[3], 1'b1);
		chk(irq[1], 1'b1);
		ctl = 6'h09;
		@(negedge clk);
		chk(irq[1], 1'b0);
		ctl = 6'h01;
		frames(3);
		chk(up_ch0[0], 1'b1);
		done("receive");
		sys_rst = 1'b1;
		repeat (32) @(negedge clk);
		sys_rst = 1'b0;
		frames(2);
		chk(rx_byte_reg, 8'h00);
		chk(fl, 5'h00);
		done("reset");
		summarize();
	end
endmodule // tb
